// File: bench/lse_ctrl0_properties.sv
// assertions on the lookup control zero ports
`timescale 1ns/1ps
`default_nettype none
module lse_ctrl0_chk (
  // clock, reset, bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // lookup
  input wire logic        lk_valid,
  input wire logic [47:0] lk_dest_addr,
  input wire logic        lk_vid_invalid,
  input wire logic        unk_vid_fwd_en,
  input wire logic        res_valid,
  input wire logic [9:0]  res_index,
  input wire logic        res_vlan_mode,
  input wire logic        res_drop,
  input wire logic        res_to_host,
  input wire logic        res_unk_vid,
  input wire logic        res_rsvd_mc_hit,
  // ageing and fields
  input wire logic        entry_update,
  input wire logic        entry_age_valid,
  input wire logic [2:0]  entry_age,
  input wire logic        vlan_enable,
  input wire logic        drop_invalid_vid,
  input wire logic [2:0]  age_count,
  input wire logic        rsvd_mc_enable,
  input wire logic [1:0]  table_hash_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // invalid vid only counts in vlan mode
  wire bad = lk_valid && vlan_enable && lk_vid_invalid;
  // ==========================================================
  // properties
  ack_take_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  vlan_mode_a:
    assert property (lk_valid |=> res_valid && res_vlan_mode == $past(vlan_enable))
      else $error("vlan mode wrong");
  drop_inv_a:
    assert property (bad && !unk_vid_fwd_en && drop_invalid_vid |=> res_drop && !res_to_host)
      else $error("not dropped");
  to_host_a:
    assert property (bad && !unk_vid_fwd_en && !drop_invalid_vid |=> res_to_host && !res_drop)
      else $error("not sent to host");
  unk_over_a:
    assert property (bad && unk_vid_fwd_en |=> res_unk_vid && !res_drop) else $error("unk vid");
  age_stamp_a:
    assert property (entry_update |=> entry_age_valid && entry_age == $past(age_count))
      else $error("age stamp wrong");
  rsvd_off_a:
    assert property (lk_valid && !rsvd_mc_enable |=> !res_rsvd_mc_hit) else $error("rsvd hit");
  direct_idx_a:
    assert property (lk_valid && table_hash_select[0] == table_hash_select[1]
      |=> res_index == $past(lk_dest_addr[9:0])) else $error("direct index wrong");
endmodule
`default_nettype wire

// File: bench/lse_ctrl0_tb.sv
// self-checking bench of lookup control zero
`timescale 1ns/1ps
`default_nettype none
`include "lse_params.svh"
module lse_ctrl0_tb;
  logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lk_valid = 0;
  logic lk_vid_invalid = 0, unk_vid_fwd_en = 0, entry_update = 0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [47:0] lk_dest_addr = 48'h0;
  logic wb_ack_o, res_valid, res_vlan_mode, res_drop, res_to_host, res_unk_vid;
  logic res_rsvd_mc_hit, entry_age_valid, vlan_enable, drop_invalid_vid, rsvd_mc_enable;
  logic [1:0]  table_hash_select;
  logic [2:0]  entry_age, age_count;
  logic [9:0]  res_index;
  logic [31:0] wb_dat_o, q;
  logic [47:0] da;
  logic [7:0]  cv [8] = '{8'hFF, 8'h00, 8'hC2, 8'h47, 8'h99, 8'h28, 8'hE6, 8'h53};
  int errors = 0, total_checks = 0, cycles = 0;
  lse_ctrl0 dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .lk_valid, .lk_dest_addr, .lk_vid_invalid, .unk_vid_fwd_en,
    .res_valid, .res_index, .res_vlan_mode, .res_drop, .res_to_host, .res_unk_vid,
    .res_rsvd_mc_hit, .entry_update, .entry_age_valid, .entry_age, .vlan_enable,
    .drop_invalid_vid, .age_count, .rsvd_mc_enable, .table_hash_select);
  initial
  begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // classic cycle, waits for ack at a rising edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  // crc reference as a long division: address times x^10 plus preset times x^48
  function automatic logic [9:0] crc_ref(input logic [47:0] a);
    logic [57:0] v;
    v = {a, 10'h000} ^ {10'h3FF, 48'h0};
    for (int i = 57; i >= 10; i--)
      if (v[i])
        v[i-:11] = v[i-:11] ^ {1'b1, `LSE_CRC_POLY};
    return v[9:0];
  endfunction
  // one lookup, expectations from the shadow value c
  task automatic lk(input logic [7:0] c, input logic inv, input logic unk);
    logic       iv;
    logic [9:0] ix;
    iv = c[7] & inv;
    ix = da[9:0];
    if (c[1:0] == 2'h1)
      ix = crc_ref(da);
    else if (c[1:0] == 2'h2)
      ix = da[9:0] ^ da[19:10] ^ da[29:20] ^ da[39:30] ^ {2'h0, da[47:40]};
    lk_valid <= 1'b1;
    lk_dest_addr <= da;
    lk_vid_invalid <= inv;
    unk_vid_fwd_en <= unk;
    @(posedge clk);
    lk_valid <= 1'b0;
    #1;
    chk("flags", 32'({res_valid, res_vlan_mode, res_drop, res_to_host, res_unk_vid}),
        32'({1'b1, c[7], iv & !unk & c[6], iv & !unk & !c[6], iv & unk}));
    chk("rsvd", 32'(res_rsvd_mc_hit), 32'(c[2] && da[47:4] == `LSE_RSVD_MC_PREFIX));
    chk("index", 32'(res_index), 32'(ix));
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard counter, run needs about 160 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
  end
  // ==========================================================
  // sequence
  initial
  begin
    fork
      begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, `LSE_CTRL0_OFFSET, 4'hF, 32'h0);
        chk("reset", q, 32'h61);
        wb(1'b1, 12'h311, 4'hF, 32'hFF);
        wb(1'b0, 12'h311, 4'hF, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, `LSE_CTRL0_OFFSET, 4'hE, 32'hFF);
        wb(1'b0, `LSE_CTRL0_OFFSET, 4'hF, 32'h0);
        chk("no sel", q, 32'h61);
        da = 48'hA5C31E7B9D46;
        lk(8'h61, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
          // vlan table sits outside this block, so bit 7 may be set at any time
          wb(1'b1, `LSE_CTRL0_OFFSET, 4'h1, {24'h0, cv[i]});
          wb(1'b0, `LSE_CTRL0_OFFSET, 4'hF, 32'h0);
          chk("readback", q, {24'h0, cv[i]});
          chk("fields", 32'({vlan_enable, drop_invalid_vid, age_count, rsvd_mc_enable,
              table_hash_select}), 32'(cv[i]));
          entry_update <= 1'b1;
          @(posedge clk);
          entry_update <= 1'b0;
          #1;
          chk("age", 32'({entry_age_valid, entry_age}), 32'({1'b1, cv[i][5:3]}));
          @(posedge clk);
          da = i[0] ? {44'h0180C200000, i[3:0]} : da ^ 48'h3F5A0C96E1B7;
          for (int u = 0; u < 4; u++)
            lk(cv[i], u[0], u[1]);
        end
      end
      begin
        wait (cycles >= 3000);
        errors++;
      end
    join_any
    print_verdict;
  end
endmodule
bind lse_ctrl0 lse_ctrl0_chk chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .lk_valid,
  .lk_dest_addr, .lk_vid_invalid, .unk_vid_fwd_en, .res_valid, .res_index, .res_vlan_mode,
  .res_drop, .res_to_host, .res_unk_vid, .res_rsvd_mc_hit, .entry_update, .entry_age_valid,
  .entry_age, .vlan_enable, .drop_invalid_vid, .age_count, .rsvd_mc_enable,
  .table_hash_select);
`default_nettype wire

// File: verilog/lse_ctrl0.sv
// lookup engine control register zero with its lookup-side decisions
//
// Operation
// R01: bit 7 master vlan enable, reset clear
// R02: software fills vlan table before enabling
// R03: bit 6 drops invalid vid, reset set
// R04: drop clear sends invalid vid to host
// R05: unknown vid forwarding overrides drop control
// R06: bits 5:3 age count, reset 100
// R07: written entries stamped with current age count
// R08: bit 2 reserved multicast lookup enable
// R09: hash 00/11 indexes by ten da bits
// R10: hash reset 01; 01 crc, 10 xor
// R11: writes affect later packets; reads return fields
`timescale 1ns/1ps
`default_nettype none
`include "lse_params.svh"

module lse_ctrl0 #(
  parameter int ADDR_W = 12,
  parameter int IDX_W  = 10
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // lookup request
  input  wire logic              lk_valid,
  input  wire logic [47:0]       lk_dest_addr,
  input  wire logic              lk_vid_invalid,
  input  wire logic              unk_vid_fwd_en,
  // lookup result
  output logic                   res_valid,
  output logic [IDX_W-1:0]       res_index,
  output logic                   res_vlan_mode,
  output logic                   res_drop,
  output logic                   res_to_host,
  output logic                   res_unk_vid,
  output logic                   res_rsvd_mc_hit,
  // dynamic entry ageing
  input  wire logic              entry_update,
  output logic                   entry_age_valid,
  output logic [2:0]             entry_age,
  // static configuration view
  output logic                   vlan_enable,
  output logic                   drop_invalid_vid,
  output logic [2:0]             age_count,
  output logic                   rsvd_mc_enable,
  output logic [1:0]             table_hash_select
);

  // ==========================================================
  // helper functions

  // crc over the destination address, msb first
  function automatic logic [IDX_W-1:0] crc_index(input logic [47:0] da);
    logic [9:0] crc;
    crc = 10'h3FF;
    for (int i = 47; i >= 0; i--)
    begin
      if (crc[9] ^ da[i])
        crc = {crc[8:0], 1'b0} ^ `LSE_CRC_POLY;
      else
        crc = {crc[8:0], 1'b0};
    end
    return IDX_W'(crc);
  endfunction

  // fold the address into ten bits by exclusive or
  function automatic logic [IDX_W-1:0] xor_index(input logic [47:0] da);
    logic [49:0] ext;
    logic [9:0]  acc;
    ext = {2'h0, da};
    acc = 10'h000;
    for (int i = 0; i < 5; i++)
    begin
      acc = acc ^ ext[i*10 +: 10];
    end
    return IDX_W'(acc);
  endfunction

  // decode of the two-bit selector
  function automatic lse_pkg::lse_map_t map_mode(input logic [1:0] sel);
    lse_pkg::lse_map_t m;
    m = lse_pkg::LSE_MAP_DIRECT;
    if (sel == 2'h1)
      m = lse_pkg::LSE_MAP_CRC;
    else if (sel == 2'h2)
      m = lse_pkg::LSE_MAP_XOR;
    return m;
  endfunction

  // ==========================================================
  // bus decode

  logic       ack;
  logic [7:0] rd_byte;

  wire bus_req  = wb_cyc_i & wb_stb_i & ~ack;
  wire hit      = (wb_adr_i == ADDR_W'(`LSE_CTRL0_OFFSET));
  wire wr_en    = bus_req & wb_we_i & hit & wb_sel_i[0];
  wire rd_sel   = bus_req & ~wb_we_i & hit;

  // ==========================================================
  // control register fields

  logic       vlan_en;
  logic       drop_inv;
  logic [2:0] age_cnt;
  logic       rsvd_mc;
  logic [1:0] hash_sel;

  wire [7:0] reg_view = {vlan_en, drop_inv, age_cnt, rsvd_mc, hash_sel};

  // write lands on the ack edge, so a packet taken at
  // that same edge still sees the old setting
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vlan_en  <= `LSE_VLAN_EN_RST;  // R01
      drop_inv <= `LSE_DROP_INV_RST; // R03
      age_cnt  <= `LSE_AGE_RST;      // R06
      rsvd_mc  <= `LSE_RSVD_MC_RST;  // R08
      hash_sel <= `LSE_HASH_RST;     // R10
    end
    else if (wr_en)
    begin
      vlan_en  <= wb_dat_i[`LSE_VLAN_EN_BIT];            // R01 R11
      drop_inv <= wb_dat_i[`LSE_DROP_INV_BIT];           // R03
      age_cnt  <= wb_dat_i[`LSE_AGE_HI:`LSE_AGE_LO];     // R06
      rsvd_mc  <= wb_dat_i[`LSE_RSVD_MC_BIT];            // R08
      hash_sel <= wb_dat_i[`LSE_HASH_HI:`LSE_HASH_LO];   // R09 R10
    end
  end

  // ==========================================================
  // bus answer

  // unmapped addresses still ack and read as zero,
  // so a stray access never hangs the bus
  assign rd_byte = rd_sel ? reg_view : 8'h00; // R11

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= bus_req;
    end
  end

  // read data launches on the same take edge as ack,
  // so it stands exactly while ack is high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack;

  // ==========================================================
  // lookup decisions

  lse_pkg::lse_map_t mode;

  logic [IDX_W-1:0] next_index;
  logic             next_drop;
  logic             next_to_host;
  logic             next_unk;
  logic             next_rsvd;

  wire [IDX_W-1:0] direct_idx = lk_dest_addr[IDX_W-1:0];
  wire [IDX_W-1:0] crc_idx    = crc_index(lk_dest_addr);
  wire [IDX_W-1:0] xor_idx    = xor_index(lk_dest_addr);

  // group addresses 01-80-C2-00-00-0x
  wire rsvd_match = (lk_dest_addr[47:4] == `LSE_RSVD_MC_PREFIX);

  // only a filtering switch judges the vid at all
  wire vid_bad = lk_vid_invalid & vlan_en; // R01

  assign mode = map_mode(hash_sel);

  always_comb
  begin
    unique case (mode)
      lse_pkg::LSE_MAP_CRC:    next_index = crc_idx;    // R10
      lse_pkg::LSE_MAP_XOR:    next_index = xor_idx;    // R10
      lse_pkg::LSE_MAP_DIRECT: next_index = direct_idx; // R09
    endcase
  end

  always_comb
  begin
    next_unk     = 1'b0;
    next_drop    = 1'b0;
    next_to_host = 1'b0;
    if (vid_bad)
    begin
      if (unk_vid_fwd_en)
        next_unk = 1'b1;          // R05
      else if (drop_inv)
        next_drop = 1'b1;         // R03
      else
        next_to_host = 1'b1;      // R04
    end
  end

  assign next_rsvd = rsvd_mc & rsvd_match; // R08

  // ==========================================================
  // lookup result registers

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      res_valid <= 1'b0;
    end
    else
    begin
      res_valid <= lk_valid;
    end
  end

  // results are captured only for a taken request so they
  // stand until the next one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      res_index <= '0;
    end
    else if (lk_valid)
    begin
      res_index <= next_index; // R11
    end
  end

  // forwarding flags, same capture rule as the index
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      res_vlan_mode   <= 1'b0;
      res_drop        <= 1'b0;
      res_to_host     <= 1'b0;
      res_unk_vid     <= 1'b0;
      res_rsvd_mc_hit <= 1'b0;
    end
    else if (lk_valid)
    begin
      res_vlan_mode   <= vlan_en;      // R01
      res_drop        <= next_drop;
      res_to_host     <= next_to_host;
      res_unk_vid     <= next_unk;
      res_rsvd_mc_hit <= next_rsvd;
    end
  end

  // ==========================================================
  // age stamp for dynamic entries

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      entry_age_valid <= 1'b0;
      entry_age       <= 3'h0;
    end
    else
    begin
      entry_age_valid <= entry_update;
      if (entry_update)
        entry_age <= age_cnt; // R07
    end
  end

  // ==========================================================
  // configuration view

  // the vlan table is assumed ready once software sets bit 7;
  // nothing here checks it
  assign vlan_enable       = vlan_en;
  assign drop_invalid_vid  = drop_inv;
  assign age_count         = age_cnt;   // R06
  assign rsvd_mc_enable    = rsvd_mc;
  assign table_hash_select = hash_sel;

endmodule

`default_nettype wire

// File: verilog/lse_params.svh
// offsets, field positions, reset values and constants of the lookup control
`ifndef LSE_PARAMS_SVH
`define LSE_PARAMS_SVH

// ==========================================================
// register map
`define LSE_CTRL0_OFFSET 12'h310

// ==========================================================
// field positions
`define LSE_VLAN_EN_BIT 7
`define LSE_DROP_INV_BIT 6
`define LSE_AGE_HI 5
`define LSE_AGE_LO 3
`define LSE_RSVD_MC_BIT 2
`define LSE_HASH_HI 1
`define LSE_HASH_LO 0

// ==========================================================
// reset values
`define LSE_VLAN_EN_RST 1'h0
`define LSE_DROP_INV_RST 1'h1
`define LSE_AGE_RST 3'h4
`define LSE_RSVD_MC_RST 1'h0
`define LSE_HASH_RST 2'h1

// ==========================================================
// hash and reserved multicast constants
`define LSE_CRC_POLY 10'h233
`define LSE_RSVD_MC_PREFIX 44'h0180C20000_0

`endif

// File: verilog/lse_pkg.sv
// types shared by the lookup engine control logic
package lse_pkg;

  // ==========================================================
  // dynamic table mapping modes
  typedef enum logic [1:0] {
    LSE_MAP_DIRECT,
    LSE_MAP_CRC,
    LSE_MAP_XOR
  } lse_map_t;

endpackage
